// ===== design/tmr_bank.sv
// Ten 8-bit reload countdown dividers with status flags and interrupt.
// Assumes processor strobes are synchronous to clk_i (peripheral clock).
//
// Summary of operation
// - Ten dividers, each with 8-bit reload value
// - Reload n gives one pulse per n+1
// - Bank clock is peripheral clock or half
// - Output pulse one cycle after zero tick; counter reloads on same edge
// - Counter at zero reloads on next input
// - Reload writes accepted at any time
// - Timers two to seven drive baud clocks
// - Timers eight to ten feed fixed peripherals
// - Timers eight to ten raise no flags
// - Timers one to seven set done flags
// - One shared interrupt output for bank
// - Status read returns and clears flags
// - Event during read survives into flag
// - Enabled set flag requests an interrupt
// - Write-only reload registers at own addresses
// - Status bits read flags, write enables
// - Status bit zero gates main clock
// - Control bits pick main clock or timer one
`timescale 1ns/1ps
`include "tmr_consts.svh"

module tmr_bank
	import tmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic irq_o,
	output logic prescale_timer_one_o,
	output logic [5:0] baud_clk_o,
	output logic capture_feed_timer_o,
	output logic pwm_feed_timer_o,
	output logic quadrature_feed_timer_o
);

	// -------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------

	// Map a reload address to its timer index
	function automatic tmr_idx_t reload_index(input tmr_byte_t addr);
		tmr_idx_t idx;
		idx = `TMR_NO_RELOAD;
		case (addr)
			`TMR_ADDR_RELOAD1: idx = 4'h0;
			`TMR_ADDR_RELOAD2: idx = 4'h1;
			`TMR_ADDR_RELOAD3: idx = 4'h2;
			`TMR_ADDR_RELOAD4: idx = 4'h3;
			`TMR_ADDR_RELOAD5: idx = 4'h4;
			`TMR_ADDR_RELOAD6: idx = 4'h5;
			`TMR_ADDR_RELOAD7: idx = 4'h6;
			`TMR_ADDR_RELOAD8: idx = 4'h7;
			`TMR_ADDR_RELOAD9: idx = 4'h8;
			`TMR_ADDR_RELOAD10: idx = 4'h9;
			default: idx = `TMR_NO_RELOAD;
		endcase
		return idx;
	endfunction : reload_index

	// Qualified strobes
	logic wr_stat;
	logic wr_pre;
	logic wr_src;
	logic rd_stat;
	tmr_idx_t wr_idx;
	assign wr_stat = ce_i && io_wr_i && (io_addr_i == `TMR_ADDR_STATUS);
	assign wr_pre = ce_i && io_wr_i && (io_addr_i == `TMR_ADDR_PRESCALE);
	assign wr_src = ce_i && io_wr_i && (io_addr_i == `TMR_ADDR_SOURCE);
	assign rd_stat = ce_i && io_rd_i && (io_addr_i == `TMR_ADDR_STATUS);
	assign wr_idx = reload_index(io_addr_i);

	// -------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------
	logic main_en;
	logic [7:1] irq_en;
	tmr_byte_t timer_bank_prescale_select;
	tmr_byte_t timer_bank_clock_source_select;

	// Enables and main clock gate, written through status offset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			main_en <= 1'b0;
			irq_en <= 7'h00;
		end else if (wr_stat) begin
			main_en <= io_wdata_i[`TMR_STAT_EN_BIT];
			irq_en <= io_wdata_i[7:1];
		end
	end

	// Prescale and clock source selection
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			timer_bank_prescale_select <= `TMR_RST_PRESCALE;
			timer_bank_clock_source_select <= `TMR_RST_SOURCE;
		end else begin
			if (wr_pre) begin
				timer_bank_prescale_select <= io_wdata_i;
			end
			if (wr_src) begin
				timer_bank_clock_source_select <= io_wdata_i;
			end
		end
	end

	// Reload values, written any time without side effects
	tmr_byte_t reload_value [`TMR_NUM_TIMERS];
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int k = 0; k < `TMR_NUM_TIMERS; k++) begin
				reload_value[k] <= `TMR_RST_RELOAD;
			end
		end else if (ce_i && io_wr_i && (wr_idx != `TMR_NO_RELOAD)) begin
			reload_value[wr_idx] <= io_wdata_i;
		end
	end

	// -------------------------------------------------------------
	// Main timer clock
	// -------------------------------------------------------------
	logic phase;
	logic base_tick;
	logic div2;
	assign div2 = timer_bank_prescale_select[`TMR_PRE_DIV2_BIT];

	// Toggle for peripheral clock divided by two
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			phase <= 1'b0;
		end else if (ce_i) begin
			phase <= !phase;
		end
	end

	// Gated base tick, every cycle or every second one
	assign base_tick = ce_i && main_en && (div2 ? phase : 1'b1);

	// -------------------------------------------------------------
	// Countdown dividers
	// -------------------------------------------------------------
	tmr_byte_t cnt [`TMR_NUM_TIMERS];
	logic [`TMR_NUM_TIMERS-1:0] tick_in;
	logic [`TMR_NUM_TIMERS-1:0] pulse;

	genvar g;
	generate
		for (g = 0; g < `TMR_NUM_TIMERS; g++) begin : gen_div
			// Input source: timers two to seven may chain from timer one
			if (g >= 1 && g <= 6) begin : gen_chain
				assign tick_in[g] = (tmr_src_t'(timer_bank_clock_source_select[g+1])
					== TMR_SRC_T1) ? (ce_i && pulse[0]) : base_tick;
			end else begin : gen_fixed
				assign tick_in[g] = base_tick;
			end

			// Count down, reload from zero, one-cycle pulse on reload
			always_ff @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					cnt[g] <= `TMR_RST_RELOAD;
					pulse[g] <= 1'b0;
				end else if (ce_i) begin
					pulse[g] <= tick_in[g] && (cnt[g] == 8'h00);
					if (tick_in[g]) begin
						if (cnt[g] == 8'h00) begin
							cnt[g] <= reload_value[g];
						end else begin
							cnt[g] <= cnt[g] - 8'h01;
						end
					end
				end
			end

			// Zero count met by an input tick
			sequence seq_zero_input;
				tick_in[g] && (cnt[g] == 8'h00);
			endsequence

			// Reload value lands, with the pulse beside it
			sequence seq_reload_taken;
				(cnt[g] == $past(reload_value[g])) && pulse[g];
			endsequence

			chk_zero_reload: assert property (@(posedge clk_i) disable iff (!rstn_i)
				seq_zero_input |=> seq_reload_taken)
				else $error("zero count did not reload with pulse");

			chk_count_down: assert property (@(posedge clk_i) disable iff (!rstn_i)
				tick_in[g] && (cnt[g] != 8'h00) |=> (cnt[g] == $past(cnt[g]) - 8'h01)
				&& !pulse[g])
				else $error("count did not step down by one");

			chk_count_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
				!tick_in[g] |=> $stable(cnt[g]))
				else $error("count moved without an input tick");

			chk_pulse_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
				ce_i && !(tick_in[g] && (cnt[g] == 8'h00)) |=> !pulse[g])
				else $error("pulse without zero count and tick");
		end
	endgenerate

	// Peripheral feeds straight from the pulse flops
	assign prescale_timer_one_o = pulse[0];
	assign baud_clk_o = pulse[6:1];
	assign capture_feed_timer_o = pulse[7];
	assign pwm_feed_timer_o = pulse[8];
	assign quadrature_feed_timer_o = pulse[9];

	// -------------------------------------------------------------
	// Status flags
	// -------------------------------------------------------------
	logic [7:1] done;
	logic [7:1] next_done;

	// Read clears; a pulse in the same cycle wins and stays set
	always_comb begin
		next_done = rd_stat ? 7'h00 : done;
		next_done = next_done | pulse[6:0];
	end

	// Only timers one to seven own flags
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			done <= 7'h00;
		end else if (ce_i) begin
			done <= next_done;
		end
	end

	// Read data, zero for any write-only or unmapped offset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			io_rdata_o <= `TMR_READ_ZERO;
		end else if (ce_i && io_rd_i) begin
			io_rdata_o <= rd_stat ? {done, 1'b0} : `TMR_READ_ZERO;
		end
	end

	// -------------------------------------------------------------
	// Interrupt request
	// -------------------------------------------------------------

	// Enables as they stand after this edge, so an enable write and the request agree
	logic [7:1] next_irq_en;
	always_comb begin
		next_irq_en = wr_stat ? io_wdata_i[7:1] : irq_en;
	end

	// Single request line for the whole bank
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(next_done & next_irq_en);
		end
	end

	// -------------------------------------------------------------
	// Bank-level checks
	// -------------------------------------------------------------
	chk_read_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_stat && (pulse[6:0] == 7'h00) |=> (done == 7'h00))
		else $error("status read left a flag set");

	chk_event_kept: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ce_i && (pulse[6:0] != 7'h00) |=> ((done & $past(pulse[6:0])) == $past(pulse[6:0])))
		else $error("terminal count event lost");

	chk_read_value: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rd_stat |=> (io_rdata_o == {$past(done), 1'b0}))
		else $error("status read returned wrong value");

	chk_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ce_i |=> (irq_o == |(done & irq_en)))
		else $error("request does not match flags and enables");

	chk_gate_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!main_en |-> !base_tick)
		else $error("main tick while gated off");

	chk_half_rate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		base_tick && div2 ##1 ce_i && div2 |-> !base_tick)
		else $error("halved clock ticked twice in a row");

	chk_enable_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr_stat |=> (irq_en == $past(io_wdata_i[7:1]))
		&& (main_en == $past(io_wdata_i[`TMR_STAT_EN_BIT])))
		else $error("status write did not set enables");

	chk_freeze: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!ce_i |=> $stable(done) && $stable(irq_o) && $stable(pulse))
		else $error("state moved while clock enable low");

endmodule : tmr_bank

// ===== design/tmr_consts.svh
// Constants for the ten-channel reload divider timer bank.
// Assumes inclusion by bare name from the package and the design.
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// -----------------------------------------------------------------
// Internal I/O offsets
// -----------------------------------------------------------------
`define TMR_ADDR_STATUS 8'hA0
`define TMR_ADDR_PRESCALE 8'hA1
`define TMR_ADDR_RELOAD1 8'hA3
`define TMR_ADDR_SOURCE 8'hA4
`define TMR_ADDR_RELOAD2 8'hA5
`define TMR_ADDR_RELOAD8 8'hA6
`define TMR_ADDR_RELOAD3 8'hA7
`define TMR_ADDR_RELOAD9 8'hA8
`define TMR_ADDR_RELOAD4 8'hA9
`define TMR_ADDR_RELOAD10 8'hAA
`define TMR_ADDR_RELOAD5 8'hAB
`define TMR_ADDR_RELOAD6 8'hAD
`define TMR_ADDR_RELOAD7 8'hAF

// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define TMR_STAT_EN_BIT 0
`define TMR_PRE_DIV2_BIT 0
`define TMR_NUM_TIMERS 10
`define TMR_NO_RELOAD 4'hF
`define TMR_RST_STATUS 8'h00
`define TMR_RST_PRESCALE 8'h01
`define TMR_RST_SOURCE 8'h00
`define TMR_RST_RELOAD 8'h00
`define TMR_READ_ZERO 8'h00

`endif

// ===== design/tmr_pkg.sv
// Types shared by the timer bank design.
// Assumes tmr_consts.svh is on the include path.
`include "tmr_consts.svh"

package tmr_pkg;
	typedef logic [7:0] tmr_byte_t;
	typedef logic [3:0] tmr_idx_t;
	// Input source of a chainable timer
	typedef enum logic [0:0] {
		TMR_SRC_MAIN = 1'b0,
		TMR_SRC_T1 = 1'b1
	} tmr_src_t;
endpackage : tmr_pkg

// ===== test/tmr_periph_model.sv
// Far-side model: serial, capture, PWM and quadrature inputs fed by the bank.
// Assumes pulse_i bit 0 is timer 1, bits 1..6 timers 2..7, bits 7..9 timers 8..10.
`timescale 1ns/1ps

module tmr_periph_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [9:0] pulse_i,
	output logic [9:0][15:0] cnt_o
);
	// -----------------------------------------------------------------
	// Pulse counters
	// -----------------------------------------------------------------
	// Each consumer counts one tick per cycle its feed is high
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_o <= '0;
		end else begin
			for (int k = 0; k < 10; k++) begin
				cnt_o[k] <= cnt_o[k] + 16'(pulse_i[k]);
			end
		end
	end
endmodule : tmr_periph_model

// ===== test/testbench.sv
// Self-checking bench for the timer bank, register port and divider rates.
// Assumes strobes are driven 1 ns after the rising edge of a 100 MHz clock.
`timescale 1ns/1ps

module testbench;
	import tmr_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce_i = 1'b1;
	logic [7:0] io_addr_i = 8'h00;
	logic io_wr_i = 1'b0;
	logic io_rd_i = 1'b0;
	logic [7:0] io_wdata_i = 8'h00;
	logic [7:0] io_rdata_o;
	logic irq_o;
	wire [9:0] pulse;
	logic [9:0][15:0] cnt;
	logic [9:0][15:0] base;
	logic [7:0] rd;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [7:0] rel [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h0B, 8'h0E, 8'hFF};
	logic [7:0] adr [10] = '{8'hA3, 8'hA5, 8'hA7, 8'hA9, 8'hAB, 8'hAD, 8'hAF, 8'hA6, 8'hA8, 8'hAA};

	// -----------------------------------------------------------------
	// Design and far-side model
	// -----------------------------------------------------------------
	tmr_bank tmr_bank_inst (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.io_addr_i(io_addr_i),
		.io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i),
		.io_wdata_i(io_wdata_i),
		.io_rdata_o(io_rdata_o),
		.irq_o(irq_o),
		.prescale_timer_one_o(pulse[0]),
		.baud_clk_o(pulse[6:1]),
		.capture_feed_timer_o(pulse[7]),
		.pwm_feed_timer_o(pulse[8]),
		.quadrature_feed_timer_o(pulse[9])
	);

	tmr_periph_model tmr_periph_model_inst (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.pulse_i(pulse),
		.cnt_o(cnt)
	);

	// -----------------------------------------------------------------
	// Clock, timeout and report
	// -----------------------------------------------------------------
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	// Cut a hang short
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("errors=%0d checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// -----------------------------------------------------------------
	// Register port tasks
	// -----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(posedge clk_i);
		#1;
		io_wr_i = 1'b0;
	endtask : wr

	// Read data lands one cycle after the strobe
	task automatic rdt(input logic [7:0] a);
		@(posedge clk_i);
		#1;
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(posedge clk_i);
		#1;
		io_rd_i = 1'b0;
		rd = io_rdata_o;
	endtask : rdt

	// Settle, then count pulses over a window that every period divides
	task automatic measure(input int div, input logic chain);
		int p;
		repeat (600) @(posedge clk_i);
		#1;
		base = cnt;
		repeat (7680) @(posedge clk_i);
		#1;
		for (int k = 0; k < 10; k++) begin
			p = (rel[k] + 1) * div;
			if (chain && k >= 1 && k <= 6) begin
				p = p * 2;
			end
			chk(cnt[k] - base[k], 16'(7680 / p));
		end
	endtask : measure

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		rdt(8'hA0);
		chk(rd, 8'h00);
		rdt(8'hA2);
		chk(rd, 8'h00);
		rdt(8'hA3);
		chk(rd, 8'h00);
		for (int k = 0; k < 10; k++) begin
			wr(adr[k], rel[k]);
		end
		wr(8'hA1, 8'h00);
		wr(8'hA0, 8'h01);
		measure(1, 1'b0);
		wr(8'hA1, 8'h01);
		measure(2, 1'b0);
		wr(8'hA1, 8'h00);
		rel[0] = 8'h01;
		wr(adr[0], rel[0]);
		wr(8'hA4, 8'hFC);
		measure(1, 1'b1);
		wr(8'hA4, 8'h00);
		rel[0] = 8'h00;
		wr(adr[0], rel[0]);
		wr(8'hA0, 8'h00);
		repeat (4) @(posedge clk_i);
		rdt(8'hA0);
		chk(rd, 8'hFE);
		chk(irq_o, 1'b0);
		rdt(8'hA0);
		chk(rd, 8'h00);
		wr(8'hA0, 8'hFE);
		repeat (3) @(posedge clk_i);
		#1;
		chk(irq_o, 1'b0);
		wr(8'hA0, 8'h03);
		repeat (4) @(posedge clk_i);
		#1;
		chk(irq_o, 1'b1);
		rdt(8'hA0);
		chk(rd & 8'h02, 8'h02);
		rdt(8'hA0);
		chk(rd & 8'h02, 8'h02);
		wr(8'hA0, 8'h00);
		repeat (4) @(posedge clk_i);
		rdt(8'hA0);
		rdt(8'hA0);
		chk(rd, 8'h00);
		chk(irq_o, 1'b0);
		// Frozen read neither answers nor clears the flags
		wr(8'hA0, 8'h01);
		repeat (30) @(posedge clk_i);
		wr(8'hA0, 8'h00);
		repeat (4) @(posedge clk_i);
		#1;
		ce_i = 1'b0;
		rdt(8'hA0);
		chk(rd, 8'h00);
		ce_i = 1'b1;
		rdt(8'hA0);
		chk(rd, 8'hFE);
		final_report();
	end
endmodule : testbench
